// ===== pdr_pkg.sv
// Package for the discharge, power-good delay and shutdown register slice
package pdr_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] DISCHARGE_CONTROL_THREE_ADDR     = 8'h42;
  localparam logic [7:0] POWER_GOOD_DELAY_ONE_ADDR        = 8'h43;
  localparam logic [7:0] FORCED_EMERGENCY_SHUTDOWN_ADDR   = 8'h91;
  localparam logic [7:0] STEP_DOWN_ONE_SLEEP_CONTROL_ADDR = 8'h92;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LOAD_SWITCH_B_TWO_LSB  = 4;
  localparam int LOAD_SWITCH_B_ONE_LSB  = 2;
  localparam int LDO3_LSB  = 0;
  localparam int SEL_W     = 2;
  localparam int DELAY_W   = 3;
  localparam int CODE_LSB  = 1;
  localparam int CODE_W    = 7;
  localparam int FORCE_SHUTDOWN_BIT_BIT  = 0;
  localparam int SLP_BIT   = 0;

  // ----------------------------------------------------------------------
  // Reset values (unprinted ones chosen neutral)
  // ----------------------------------------------------------------------
  localparam logic [7:0] DISCH_RST = 8'h15;
  localparam logic [2:0] DELAY_RST = 3'h0;
  localparam logic [7:0] SLEEP_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] SEL_NONE  = 2'h0;

  // ----------------------------------------------------------------------
  // Discharge path decode
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PDR_DIS_NONE = 2'b00,
    PDR_DIS_100  = 2'b01,
    PDR_DIS_200  = 2'b10,
    PDR_DIS_500  = 2'b11
  } pdr_discharge_type;

  // ----------------------------------------------------------------------
  // Output pin three usage
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PDR_PIN_POWER_GOOD = 2'b00,
    PDR_PIN_LEVEL_SHIFT = 2'b01,
    PDR_PIN_HOST_DRIVEN = 2'b10
  } pdr_pin_mode_type;

  // ----------------------------------------------------------------------
  // Timing: delays in microseconds, clock in MHz
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int US_PER_TICK = 1;
  localparam int TICK_CYCLES = CLK_MHZ * US_PER_TICK;
  localparam int DELAY_US_0 = 2500;
  localparam int DELAY_US_1 = 5000;
  localparam int DELAY_US_2 = 10000;
  localparam int DELAY_US_3 = 15000;
  localparam int DELAY_US_4 = 20000;
  localparam int DELAY_US_5 = 50000;
  localparam int DELAY_US_6 = 75000;
  localparam int DELAY_US_7 = 100000;
  localparam int TICK_CNT_W = 17;
endpackage : pdr_pkg

// ===== pdr_good_delay.sv
// Power-good delay timer for output pin three
`timescale 1ns/1ns
module pdr_good_delay #(
  parameter int TICK_LEN = pdr_pkg::TICK_CYCLES
) (
  input  wire logic                        CLK_I,
  input  wire logic                        RST_N_I,
  input  wire logic                        clr_i,
  input  wire logic                        all_in_reg_i,
  input  wire logic [pdr_pkg::DELAY_W-1:0] sel_i,
  output logic                             good_o
);
  import pdr_pkg::*;

  // The prescaler is 16 bits wide, so the tick length has to fit in it
  if (TICK_LEN < 1 || TICK_LEN > 65536) begin : g_bad_tick
    $error("TICK_LEN must be between 1 and 65536 cycles");
  end

  logic [15:0]           pre_q, pre_d;
  logic [TICK_CNT_W-1:0] tick_q, tick_d;
  logic                  good_q, good_d;
  logic [TICK_CNT_W-1:0] limit;

  // Delay target in microsecond ticks
  always_comb begin
    case (sel_i)
      3'h0:    limit = TICK_CNT_W'(DELAY_US_0);
      3'h1:    limit = TICK_CNT_W'(DELAY_US_1);
      3'h2:    limit = TICK_CNT_W'(DELAY_US_2);
      3'h3:    limit = TICK_CNT_W'(DELAY_US_3);
      3'h4:    limit = TICK_CNT_W'(DELAY_US_4);
      3'h5:    limit = TICK_CNT_W'(DELAY_US_5);
      3'h6:    limit = TICK_CNT_W'(DELAY_US_6);
      default: limit = TICK_CNT_W'(DELAY_US_7);
    endcase
  end

  // Count only while every grouped rail is in regulation; drop at once otherwise
  always_comb begin
    pre_d  = pre_q;
    tick_d = tick_q;
    good_d = good_q;
    if (clr_i || !all_in_reg_i) begin
      pre_d  = '0;
      tick_d = '0;
      good_d = 1'b0;
    end else if (!good_q) begin
      if (pre_q == 16'(TICK_LEN - 1)) begin
        pre_d  = '0;
        tick_d = tick_q + 1'b1;
        if (tick_q + 1'b1 >= limit) good_d = 1'b1;
      end else begin
        pre_d = pre_q + 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pre_q  <= '0;
      tick_q <= '0;
      good_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
      good_q <= good_d;
    end
  end

  assign good_o = good_q;
endmodule : pdr_good_delay

// ===== pdr_regs.sv
// Discharge, power-good delay, forced shutdown and sleep control registers
//
// Behaviour
// - Discharge field forced to 00 while its rail is enabled.
// - Discharge register: B2 at 5:4, B1 at 3:2, aux LDO at 1:0.
// - Field codes: 00 none, 01 100 ohm, 10 200 ohm, 11 500 ohm.
// - Delay counts once all grouped rails regulate; then power good asserts.
// - Delay code picks 2.5, 5, 10, 15, 20, 50, 75 or 100 ms.
// - Pin three is power good, level shifter or host-driven output.
// - Host-driven pin without termination enable ignores delay; default 0.
// - Writing 1 to shutdown bit 0 starts shutdown; 0 does nothing.
// - Shutdown resets the whole controller and every register.
// - Shutdown bit clears itself, never reads back as 1.
// - A shutdown data byte with bit 0 set is not acknowledged; one with bit 0 clear is.
// - Sleep register bits 7:1 hold the sleep voltage code.
// - Sleep bit 0 selects sleep code while sleep pin low, else normal.
`timescale 1ns/1ns
module pdr_regs #(
  parameter int TICK_LEN = pdr_pkg::TICK_CYCLES
) (
  input  wire logic                             CLK_I,
  input  wire logic                             RST_N_I,
  // Register port from the serial target logic
  input  wire logic                             WR_EN_I,
  input  wire logic                             RD_EN_I,
  input  wire logic [7:0]                       ADDR_I,
  input  wire logic [7:0]                       WDATA_I,
  output logic      [7:0]                       RDATA_O,
  output logic                                  ACK_O,
  // Rail status
  input  wire logic                             LOAD_SWITCH_B_TWO_EN_I,
  input  wire logic                             LOAD_SWITCH_B_ONE_EN_I,
  input  wire logic                             LDO3_EN_I,
  input  wire logic                             GROUP_IN_REG_I,
  input  wire pdr_pkg::pdr_pin_mode_type        PIN_MODE_I,
  input  wire logic                             TERM_REG_USE_I,
  input  wire logic                             HOST_PIN_LEVEL_I,
  input  wire logic                             LEVEL_SHIFT_IN_I,
  input  wire logic                             SLEEP_PIN_N_I,
  input  wire logic [pdr_pkg::CODE_W-1:0]       NORMAL_CODE_I,
  // Outputs
  output logic [1:0]                            LOAD_SWITCH_B_TWO_DISCHARGE_O,
  output logic [1:0]                            LOAD_SWITCH_B_ONE_DISCHARGE_O,
  output logic [1:0]                            LDO3_DISCHARGE_O,
  output logic                                  OUT_PIN_THREE_O,
  output logic [pdr_pkg::CODE_W-1:0]            STEP_CODE_O,
  output logic                                  SHUTDOWN_O
);
  import pdr_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [5:0]         disch_q, disch_d;
  logic [DELAY_W-1:0] delay_q, delay_d;
  logic [7:0]         sleep_q, sleep_d;
  logic               force_shutdown_bit_q, force_shutdown_bit_d;
  logic [7:0]         rdata_q, rdata_d;
  logic               ack_q, ack_d;
  logic [1:0]         load_switch_b_two_q, load_switch_b_one_q, ldo3_q;
  logic [1:0]         load_switch_b_two_d, load_switch_b_one_d, ldo3_d;
  logic               pin_q, pin_d;
  logic [CODE_W-1:0]  code_q, code_d;
  logic               good;
  logic               delay_active;
  logic               wr_disch, wr_delay, wr_force_shutdown_bit, wr_sleep;
  logic               sys_rst_n;

  // Shutdown acts as a controller-wide synchronous reset one cycle later
  assign sys_rst_n = RST_N_I && !force_shutdown_bit_q;

  assign wr_disch = WR_EN_I && (ADDR_I == DISCHARGE_CONTROL_THREE_ADDR);
  assign wr_delay = WR_EN_I && (ADDR_I == POWER_GOOD_DELAY_ONE_ADDR);
  assign wr_force_shutdown_bit  = WR_EN_I && (ADDR_I == FORCED_EMERGENCY_SHUTDOWN_ADDR);
  assign wr_sleep = WR_EN_I && (ADDR_I == STEP_DOWN_ONE_SLEEP_CONTROL_ADDR);

  // --------------------------------------------------------------------
  // Register writes and read mux
  // --------------------------------------------------------------------
  always_comb begin
    disch_d = disch_q;
    delay_d = delay_q;
    sleep_d = sleep_q;
    force_shutdown_bit_d  = 1'b0;
    ack_d   = 1'b0;
    rdata_d = rdata_q;
    if (wr_disch) disch_d = WDATA_I[5:0];
    if (wr_delay) delay_d = WDATA_I[DELAY_W-1:0];
    if (wr_sleep) sleep_d = WDATA_I;
    if (wr_force_shutdown_bit) begin
      force_shutdown_bit_d = WDATA_I[FORCE_SHUTDOWN_BIT_BIT];
    end
    // Fields clear while the owning rail is on; write of the same cycle loses
    if (LOAD_SWITCH_B_TWO_EN_I) disch_d[LOAD_SWITCH_B_TWO_LSB +: SEL_W] = SEL_NONE;
    if (LOAD_SWITCH_B_ONE_EN_I) disch_d[LOAD_SWITCH_B_ONE_LSB +: SEL_W] = SEL_NONE;
    if (LDO3_EN_I) disch_d[LDO3_LSB +: SEL_W] = SEL_NONE;
    // Every write is acknowledged except a shutdown request
    if (WR_EN_I) ack_d = !(wr_force_shutdown_bit && WDATA_I[FORCE_SHUTDOWN_BIT_BIT]);
    if (RD_EN_I) begin
      ack_d = 1'b1;
      case (ADDR_I)
        DISCHARGE_CONTROL_THREE_ADDR:     rdata_d = {2'h0, disch_q};
        POWER_GOOD_DELAY_ONE_ADDR:        rdata_d = {5'h00, delay_q};
        FORCED_EMERGENCY_SHUTDOWN_ADDR:   rdata_d = ZERO_BYTE;
        STEP_DOWN_ONE_SLEEP_CONTROL_ADDR: rdata_d = sleep_q;
        default:                          rdata_d = ZERO_BYTE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Output decode: discharge paths, pin three, regulator code
  // --------------------------------------------------------------------
  // Delay only counts in the power-good usage or when the pin enables termination
  assign delay_active = (PIN_MODE_I == PDR_PIN_POWER_GOOD) || TERM_REG_USE_I;

  always_comb begin
    load_switch_b_two_d = disch_q[LOAD_SWITCH_B_TWO_LSB +: SEL_W];
    load_switch_b_one_d = disch_q[LOAD_SWITCH_B_ONE_LSB +: SEL_W];
    ldo3_d = disch_q[LDO3_LSB +: SEL_W];
    // Rail enable gates the path too, so a path is off from one cycle after its rail turns on
    if (LOAD_SWITCH_B_TWO_EN_I) load_switch_b_two_d = PDR_DIS_NONE;
    if (LOAD_SWITCH_B_ONE_EN_I) load_switch_b_one_d = PDR_DIS_NONE;
    if (LDO3_EN_I) ldo3_d = PDR_DIS_NONE;
    case (PIN_MODE_I)
      PDR_PIN_POWER_GOOD:  pin_d = good;
      PDR_PIN_LEVEL_SHIFT: pin_d = LEVEL_SHIFT_IN_I;
      PDR_PIN_HOST_DRIVEN: pin_d = HOST_PIN_LEVEL_I;
      default:             pin_d = 1'b0;
    endcase
    // Sleep code only while the select bit is set and the sleep pin is low
    if (sleep_q[SLP_BIT] && !SLEEP_PIN_N_I) code_d = sleep_q[CODE_LSB +: CODE_W];
    else                                   code_d = NORMAL_CODE_I;
  end

  pdr_good_delay #(
    .TICK_LEN (TICK_LEN)
  ) u_delay (
    .CLK_I        (CLK_I),
    .RST_N_I      (sys_rst_n),
    .clr_i        (!delay_active),
    .all_in_reg_i (GROUP_IN_REG_I),
    .sel_i        (delay_q),
    .good_o       (good)
  );

  // --------------------------------------------------------------------
  // Registers; shutdown returns all of them to reset values
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!sys_rst_n) begin
      disch_q <= DISCH_RST[5:0];
      delay_q <= DELAY_RST;
      sleep_q <= SLEEP_RST;
      force_shutdown_bit_q  <= 1'b0;
      rdata_q <= ZERO_BYTE;
      ack_q   <= 1'b0;
      load_switch_b_two_q  <= SEL_NONE;
      load_switch_b_one_q  <= SEL_NONE;
      ldo3_q  <= SEL_NONE;
      pin_q   <= 1'b0;
      code_q  <= '0;
    end else begin
      disch_q <= disch_d;
      delay_q <= delay_d;
      sleep_q <= sleep_d;
      force_shutdown_bit_q  <= force_shutdown_bit_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
      load_switch_b_two_q  <= load_switch_b_two_d;
      load_switch_b_one_q  <= load_switch_b_one_d;
      ldo3_q  <= ldo3_d;
      pin_q   <= pin_d;
      code_q  <= code_d;
    end
  end

  // Outputs straight from flip-flops
  assign RDATA_O          = rdata_q;
  assign ACK_O            = ack_q;
  assign LOAD_SWITCH_B_TWO_DISCHARGE_O = load_switch_b_two_q;
  assign LOAD_SWITCH_B_ONE_DISCHARGE_O = load_switch_b_one_q;
  assign LDO3_DISCHARGE_O = ldo3_q;
  assign OUT_PIN_THREE_O  = pin_q;
  assign STEP_CODE_O      = code_q;
  assign SHUTDOWN_O       = force_shutdown_bit_q;
endmodule : pdr_regs

// ===== pdr_regs_properties.sv
// Port-level checker for the register slice
`timescale 1ns/1ns
module pdr_regs_properties (
  input wire logic                      CLK_I,
  input wire logic                      RST_N_I,
  input wire logic                      WR_EN_I,
  input wire logic                      RD_EN_I,
  input wire logic [7:0]                ADDR_I,
  input wire logic [7:0]                WDATA_I,
  input wire logic [7:0]                RDATA_O,
  input wire logic                      ACK_O,
  input wire logic                      LOAD_SWITCH_B_TWO_EN_I,
  input wire logic                      LDO3_EN_I,
  input wire logic                      GROUP_IN_REG_I,
  input wire pdr_pkg::pdr_pin_mode_type PIN_MODE_I,
  input wire logic                      HOST_PIN_LEVEL_I,
  input wire logic                      SLEEP_PIN_N_I,
  input wire logic [6:0]                NORMAL_CODE_I,
  input wire logic [1:0]                LOAD_SWITCH_B_TWO_DISCHARGE_O,
  input wire logic [1:0]                LDO3_DISCHARGE_O,
  input wire logic                      OUT_PIN_THREE_O,
  input wire logic [6:0]                STEP_CODE_O,
  input wire logic                      SHUTDOWN_O
);
  import pdr_pkg::*;
  // ---------------------------------------------------------------
  // Sequences; internal shutdown reset is kept out of the windows
  // ---------------------------------------------------------------
  logic sd_w;
  assign sd_w = WR_EN_I && ADDR_I == FORCED_EMERGENCY_SHUTDOWN_ADDR && WDATA_I[FORCE_SHUTDOWN_BIT_BIT];
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  sequence s_awake;
    (RST_N_I && !SHUTDOWN_O && SLEEP_PIN_N_I) ##1 SLEEP_PIN_N_I;
  endsequence
  sequence s_host;
    (RST_N_I && !SHUTDOWN_O && PIN_MODE_I == PDR_PIN_HOST_DRIVEN) ##1 PIN_MODE_I == PDR_PIN_HOST_DRIVEN;
  endsequence
  // Handshake and shutdown
  AST_ACK: assert property ((RD_EN_I || (WR_EN_I && !sd_w)) |=> ACK_O)
    else $error("request not acknowledged");
  AST_FORCE_SHUTDOWN_BIT_NOACK: assert property (sd_w |=> SHUTDOWN_O && !ACK_O)
    else $error("shutdown write mishandled");
  AST_FORCE_SHUTDOWN_BIT_IDLE: assert property (!sd_w |=> !SHUTDOWN_O)
    else $error("shutdown without command");
  AST_FORCE_SHUTDOWN_BIT_ONCE: assert property (SHUTDOWN_O |=> !SHUTDOWN_O)
    else $error("shutdown pulse too long");
  // Discharge fields under enabled rails
  AST_DIS_B2: assert property ((LOAD_SWITCH_B_TWO_EN_I && !SHUTDOWN_O) [*3] |-> LOAD_SWITCH_B_TWO_DISCHARGE_O == SEL_NONE)
    else $error("switch b2 discharge active while enabled");
  AST_DIS_A3: assert property ((LDO3_EN_I && !SHUTDOWN_O) [*3] |-> LDO3_DISCHARGE_O == SEL_NONE)
    else $error("aux ldo discharge active while enabled");
  // Reads
  AST_RD_FORCE_SHUTDOWN_BIT: assert property (RD_EN_I && ADDR_I == FORCED_EMERGENCY_SHUTDOWN_ADDR |=> RDATA_O == ZERO_BYTE)
    else $error("shutdown register not zero");
  AST_RD_DELAY: assert property (RD_EN_I && ADDR_I == POWER_GOOD_DELAY_ONE_ADDR |=> RDATA_O[7:3] == 5'h00)
    else $error("delay reserved bits not zero");
  // Code selection and pin three
  AST_STEP_NORM: assert property (s_awake |-> STEP_CODE_O == $past(NORMAL_CODE_I))
    else $error("normal code not used while awake");
  AST_PIN_HOST: assert property (s_host |-> OUT_PIN_THREE_O == $past(HOST_PIN_LEVEL_I))
    else $error("host-driven pin level wrong");
  AST_PG_LOW: assert property ((!GROUP_IN_REG_I && PIN_MODE_I == PDR_PIN_POWER_GOOD) [*4] |-> !OUT_PIN_THREE_O)
    else $error("power good high without regulation");
endmodule : pdr_regs_properties

bind pdr_regs pdr_regs_properties pdr_regs_properties_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .WR_EN_I(WR_EN_I),
  .RD_EN_I(RD_EN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .ACK_O(ACK_O), .LOAD_SWITCH_B_TWO_EN_I(LOAD_SWITCH_B_TWO_EN_I),
  .LDO3_EN_I(LDO3_EN_I), .GROUP_IN_REG_I(GROUP_IN_REG_I), .PIN_MODE_I(PIN_MODE_I), .HOST_PIN_LEVEL_I(HOST_PIN_LEVEL_I),
  .SLEEP_PIN_N_I(SLEEP_PIN_N_I), .NORMAL_CODE_I(NORMAL_CODE_I), .LOAD_SWITCH_B_TWO_DISCHARGE_O(LOAD_SWITCH_B_TWO_DISCHARGE_O),
  .LDO3_DISCHARGE_O(LDO3_DISCHARGE_O), .OUT_PIN_THREE_O(OUT_PIN_THREE_O), .STEP_CODE_O(STEP_CODE_O),
  .SHUTDOWN_O(SHUTDOWN_O));

// ===== pdr_host_model.sv
// Host controller model issuing single-byte register requests
`timescale 1ns/1ns
module pdr_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       ack_i,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o
);
  // ---------------------------------------------------------------
  // Request task
  // ---------------------------------------------------------------
  initial begin
    {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h00000;
  end
  // Strobe is a one-cycle pulse, answer taken at the next edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic k,
                      output logic [7:0] q);
    @(posedge clk_i);
    #1;
    {wr_en_o, rd_en_o, addr_o, wdata_o} = {wr, !wr, a, d};
    @(posedge clk_i);
    #1;
    k = ack_i;
    q = rdata_i;
    {wr_en_o, rd_en_o, addr_o, wdata_o} = {2'b00, ~a, ~d}; // Released lines lose the old value
  endtask : xfer
endmodule : pdr_host_model

// ===== tb.sv
// Self-checking testbench for the register slice
`timescale 1ns/1ns
module tb;
  import pdr_pkg::*;
  localparam int TL = 1;
  logic clk, rst_n, wr_en, rd_en, ack, sd, pin, b2e, b1e, a3e, grp, term, hlev, lsin, slp_n;
  logic [7:0] addr, wdata, rdata, rb, v;
  logic [1:0] d2, d1, d3;
  logic [6:0] ncode, scode;
  pdr_pin_mode_type mode;
  int n_fail, check_count, cyc, n;
  // ---------------------------------------------------------------
  // Clock, design and host
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  pdr_regs #(.TICK_LEN(TL)) pdr_regs_i (.CLK_I(clk), .RST_N_I(rst_n), .WR_EN_I(wr_en), .RD_EN_I(rd_en),
    .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .ACK_O(ack), .LOAD_SWITCH_B_TWO_EN_I(b2e), .LOAD_SWITCH_B_ONE_EN_I(b1e), .LDO3_EN_I(a3e),
    .GROUP_IN_REG_I(grp), .PIN_MODE_I(mode), .TERM_REG_USE_I(term), .HOST_PIN_LEVEL_I(hlev), .LEVEL_SHIFT_IN_I(lsin),
    .SLEEP_PIN_N_I(slp_n), .NORMAL_CODE_I(ncode), .LOAD_SWITCH_B_TWO_DISCHARGE_O(d2), .LOAD_SWITCH_B_ONE_DISCHARGE_O(d1),
    .LDO3_DISCHARGE_O(d3), .OUT_PIN_THREE_O(pin), .STEP_CODE_O(scode), .SHUTDOWN_O(sd));
  pdr_host_model pdr_host_model_i (.clk_i(clk), .rdata_i(rdata), .ack_i(ack), .wr_en_o(wr_en), .rd_en_o(rd_en),
    .addr_o(addr), .wdata_o(wdata));
  // Tasks and expectation helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic ek, output logic [7:0] q);
    logic k;
    pdr_host_model_i.xfer(wr, a, d, k, q);
    chk("ack", {7'h00, ek}, {7'h00, k});
  endtask : acc
  task automatic cyc_wait(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc_wait
  function automatic int dly(input int c);
    int t [8] = '{DELAY_US_0, DELAY_US_1, DELAY_US_2, DELAY_US_3, DELAY_US_4, DELAY_US_5, DELAY_US_6, DELAY_US_7};
    return t[c] * TL;
  endfunction : dly
  task automatic reset_vals();
    logic [7:0] a [5] = '{8'h42, 8'h43, 8'h91, 8'h92, 8'h7e};
    logic [7:0] e [5] = '{DISCH_RST, {5'h00, DELAY_RST}, ZERO_BYTE, SLEEP_RST, ZERO_BYTE};
    foreach (a[i]) begin
      acc(1'b0, a[i], 8'h00, 1'b1, rb);
      chk("reset value", e[i], rb);
    end
  endtask : reset_vals
  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // Hang guard: a full run needs about 57700 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      n_fail++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    {rst_n, b2e, b1e, a3e, grp, term, hlev, lsin, slp_n} = 9'h001;
    ncode = 7'h00;
    mode = PDR_PIN_POWER_GOOD;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    void'($urandom(92));
    reset_vals();
    acc(1'b1, 8'h7e, 8'($urandom), 1'b1, rb);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hff : 8'($urandom);
      acc(1'b1, DISCHARGE_CONTROL_THREE_ADDR, v, 1'b1, rb);
      acc(1'b0, DISCHARGE_CONTROL_THREE_ADDR, 8'h00, 1'b1, rb);
      chk("discharge reg", v & 8'h3f, rb);
      chk("discharge out", v & 8'h3f, {2'b00, d2, d1, d3});
    end
    {b2e, b1e, a3e} = 3'h7;
    acc(1'b1, DISCHARGE_CONTROL_THREE_ADDR, 8'h3f, 1'b1, rb);
    acc(1'b0, DISCHARGE_CONTROL_THREE_ADDR, 8'h00, 1'b1, rb);
    chk("forced field", 8'h00, rb);
    chk("forced out", 8'h00, {2'b00, d2, d1, d3});
    {b2e, b1e, a3e} = 3'h0;
    v = 8'($urandom);
    acc(1'b1, POWER_GOOD_DELAY_ONE_ADDR, v, 1'b1, rb);
    acc(1'b0, POWER_GOOD_DELAY_ONE_ADDR, 8'h00, 1'b1, rb);
    chk("delay reg", v & 8'h07, rb);
    v = 8'($urandom) | 8'h01;
    ncode = 7'($urandom);
    acc(1'b1, STEP_DOWN_ONE_SLEEP_CONTROL_ADDR, v, 1'b1, rb);
    acc(1'b0, STEP_DOWN_ONE_SLEEP_CONTROL_ADDR, 8'h00, 1'b1, rb);
    chk("sleep reg", v, rb);
    slp_n = 1'b0;
    cyc_wait(3);
    chk("sleep code", {1'b0, v[7:1]}, {1'b0, scode});
    slp_n = 1'b1;
    cyc_wait(3);
    chk("normal code", {1'b0, ncode}, {1'b0, scode});
    acc(1'b1, STEP_DOWN_ONE_SLEEP_CONTROL_ADDR, v & 8'hfe, 1'b1, rb);
    slp_n = 1'b0;
    cyc_wait(3);
    chk("select off", {1'b0, ncode}, {1'b0, scode});
    mode = PDR_PIN_HOST_DRIVEN;
    grp = 1'b1;
    // Host-driven then level-shift use; the unused input carries the opposite level
    for (int h = 0; h < 4; h++) begin
      mode = h[1] ? PDR_PIN_LEVEL_SHIFT : PDR_PIN_HOST_DRIVEN;
      {hlev, lsin} = h[1] ? {~h[0], h[0]} : {h[0], ~h[0]};
      cyc_wait(3);
      chk("pin three", {7'h00, h[0]}, {7'h00, pin});
    end
    {grp, hlev, lsin} = 3'b000;
    mode = PDR_PIN_POWER_GOOD;
    cyc_wait(4);
    // Longer codes would overrun the run length, so only the first five are timed
    for (int c = 0; c < 5; c++) begin
      acc(1'b1, POWER_GOOD_DELAY_ONE_ADDR, {5'h00, 3'(c)}, 1'b1, rb);
      grp = 1'b1;
      n = 0;
      while (pin !== 1'b1 && n < 30000) begin
        cyc_wait(1);
        n++;
      end
      chk_rng("good delay", dly(c) * 9 / 10, dly(c) * 11 / 10, n);
      grp = 1'b0;
      cyc_wait(4);
      chk("good drop", 8'h00, {7'h00, pin});
    end
    // Host-driven pin: the delay only runs while it also enables the termination regulator
    acc(1'b1, POWER_GOOD_DELAY_ONE_ADDR, 8'h00, 1'b1, rb);
    for (int t = 0; t < 2; t++) begin
      mode = PDR_PIN_HOST_DRIVEN;
      {term, grp} = {t[0], 1'b1};
      cyc_wait(dly(0) + 8);
      mode = PDR_PIN_POWER_GOOD;
      cyc_wait(3);
      chk("termination use", {7'h00, t[0]}, {7'h00, pin});
      {term, grp} = 2'b00;
      cyc_wait(4);
    end
    acc(1'b1, DISCHARGE_CONTROL_THREE_ADDR, 8'h2a, 1'b1, rb);
    acc(1'b1, FORCED_EMERGENCY_SHUTDOWN_ADDR, 8'h00, 1'b1, rb);
    chk("idle shutdown", 8'h00, {7'h00, sd});
    acc(1'b1, FORCED_EMERGENCY_SHUTDOWN_ADDR, 8'hff, 1'b0, rb);
    chk("shutdown", 8'h01, {7'h00, sd});
    reset_vals();
    close_out();
  end
endmodule : tb
